//--- core/can_bit_timing_sync.sv
// CAN bit timing and synchronisation with APB configuration and status.
// Assumes can_rx is asynchronous; protocol engine signals are on pclk.
`timescale 1ns/1ns
`default_nettype none
module can_bit_timing_sync
  import can_bit_timing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx,
  output logic can_tx,
  input wire logic bus_idle,
  input wire logic transmitting,
  input wire logic tx_bit,
  output logic bit_start,
  output logic sample_strobe,
  output logic sample_bit
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode

  logic [CFG_W-1:0] cfg_q;
  logic [CFG_PRESC_W-1:0] presc;
  logic [4:0] jw_len;
  logic [4:0] prop_len;
  logic [4:0] ph1_len;
  logic [4:0] ph2_own;
  logic [4:0] ph2_base;
  logic triple_sel;
  logic ph2_mode;

  assign presc = cfg_q[CFG_PRESC_LSB +: CFG_PRESC_W];
  assign jw_len = {3'h0, cfg_q[CFG_JW_LSB +: 2]} + 5'h01;
  assign prop_len = {2'h0, cfg_q[CFG_PROP_LSB +: 3]} + 5'h01;
  assign ph1_len = {2'h0, cfg_q[CFG_PH1_LSB +: 3]} + 5'h01;
  assign ph2_own = {2'h0, cfg_q[CFG_PH2_LSB +: 3]} + 5'h01;
  assign triple_sel = cfg_q[CFG_TRIPLE_BIT];
  assign ph2_mode = cfg_q[CFG_MODE_BIT];

  // Phase two length, never below the processing time
  always_comb begin
    if (ph2_mode) begin
      ph2_base = (ph2_own < PH2_MIN_TQ) ? PH2_MIN_TQ : ph2_own;
    end else begin
      ph2_base = (ph1_len < PROC_TIME_TQ) ? PROC_TIME_TQ : ph1_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quantum generation

  logic restart;
  logic half_tick;
  logic tq_tick;

  quantum_prescaler #(
    .W(CFG_PRESC_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .restart(restart),
    .setting(presc),
    .half_tick(half_tick),
    .tq_tick(tq_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser and edge detect

  logic rx_meta_q;
  logic rx_s_q;
  logic rx_prev_q;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (ce) begin
      rx_meta_q <= can_rx;
      rx_s_q <= rx_meta_q;
      rx_prev_q <= rx_s_q;
    end
  end

  assign fall = rx_prev_q && !rx_s_q;

  ////////////////////////////////////////////////////////////////////////////
  // Segment state and synchronisation decisions

  seg_t seg_q;
  logic [4:0] seg_cnt_q;
  logic [4:0] ext_q;
  logic [4:0] cut_q;
  logic sync_done_q;
  logic sampled_q;
  logic [4:0] seg_len;
  logic [4:0] ph1_eff;
  logic [4:0] ph2_eff;
  logic [4:0] pos_err;
  logic [4:0] neg_err;
  logic seg_end;
  logic edge_ok;
  logic hard_sync;
  logic resync_ok;
  logic is_pos;
  logic is_neg;
  logic sync_taken;
  logic lengthen;
  logic shorten;
  logic natural_start;
  logic sample_pt;

  assign ph1_eff = ph1_len + ext_q;
  assign ph2_eff = ph2_base - cut_q;

  always_comb begin
    case (seg_q)
      SEG_SYNC: seg_len = SYNC_SEG_TQ;
      SEG_PROP: seg_len = prop_len;
      SEG_PH1: seg_len = ph1_eff;
      SEG_PH2: seg_len = ph2_eff;
      default: seg_len = SYNC_SEG_TQ;
    endcase
  end

  assign seg_end = tq_tick && ((seg_cnt_q + 5'h01) >= seg_len);

  // Phase error in quanta from the sync segment
  always_comb begin
    pos_err = 5'h00;
    neg_err = 5'h00;
    case (seg_q)
      SEG_PROP: pos_err = seg_cnt_q + 5'h01;
      SEG_PH1: pos_err = prop_len + seg_cnt_q + 5'h01;
      SEG_PH2: neg_err = ph2_eff - seg_cnt_q;
      default: pos_err = 5'h00;
    endcase
  end

  assign is_pos = (seg_q == SEG_PROP) || (seg_q == SEG_PH1);
  assign is_neg = (seg_q == SEG_PH2);
  assign edge_ok = ce && fall && sampled_q && !sync_done_q;
  assign hard_sync = edge_ok && bus_idle;
  assign resync_ok = edge_ok && !bus_idle;
  assign restart = hard_sync
    || (resync_ok && is_pos && !transmitting && (pos_err <= jw_len))
    || (resync_ok && is_neg && (neg_err <= jw_len));
  assign lengthen = resync_ok && is_pos && !transmitting && (pos_err > jw_len);
  assign shorten = resync_ok && is_neg && (neg_err > jw_len);
  assign sync_taken = hard_sync
    || (resync_ok && ((seg_q == SEG_SYNC) || is_neg || (is_pos && !transmitting)));
  assign natural_start = seg_end && (seg_q == SEG_PH2) && !restart;
  assign sample_pt = seg_end && (seg_q == SEG_PH1) && !restart;

  // Segment sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_q <= SEG_SYNC;
      seg_cnt_q <= 5'h00;
    end else if (ce) begin
      if (restart) begin
        seg_q <= SEG_SYNC;
        seg_cnt_q <= 5'h00;
      end else if (seg_end) begin
        seg_cnt_q <= 5'h00;
        case (seg_q)
          SEG_SYNC: seg_q <= SEG_PROP;
          SEG_PROP: seg_q <= SEG_PH1;
          SEG_PH1: seg_q <= SEG_PH2;
          SEG_PH2: seg_q <= SEG_SYNC;
          default: seg_q <= SEG_SYNC;
        endcase
      end else if (tq_tick) begin
        seg_cnt_q <= seg_cnt_q + 5'h01;
      end
    end
  end

  // Phase adjustments, cleared at each new bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 5'h00;
      cut_q <= 5'h00;
    end else if (ce) begin
      if (restart || natural_start) begin
        ext_q <= 5'h00;
        cut_q <= 5'h00;
      end else if (lengthen) begin
        ext_q <= jw_len;
      end else if (shorten) begin
        cut_q <= jw_len;
      end
    end
  end

  // One synchronisation per bit; a new sync wins over the bit-start clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_done_q <= 1'b0;
    end else if (ce) begin
      if (sync_taken) begin
        sync_done_q <= 1'b1;
      end else if (natural_start) begin
        sync_done_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling and strobes to the protocol engine

  logic [1:0] hist_q;
  logic bit_val;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= 2'h3;
    end else if (ce && (half_tick || tq_tick)) begin
      hist_q <= {hist_q[0], rx_s_q};
    end
  end

  always_comb begin
    if (triple_sel) begin
      bit_val = (hist_q[1] & hist_q[0]) | (hist_q[1] & rx_s_q) | (hist_q[0] & rx_s_q);
    end else begin
      bit_val = rx_s_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_q <= SAMPLED_RESET;
      sample_strobe <= 1'b0;
      sample_bit <= SAMPLED_RESET;
      bit_start <= 1'b0;
      can_tx <= 1'b1;
    end else if (ce) begin
      sample_strobe <= sample_pt;
      bit_start <= restart || natural_start;
      if (sample_pt) begin
        sampled_q <= bit_val;
        sample_bit <= bit_val;
      end
      if (restart || natural_start) begin
        can_tx <= tx_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation counters for status

  logic [7:0] hard_cnt_q;
  logic [7:0] resync_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_cnt_q <= 8'h00;
      resync_cnt_q <= 8'h00;
    end else if (ce) begin
      if (hard_sync) begin
        hard_cnt_q <= hard_cnt_q + 8'h01;
      end
      if (restart && !hard_sync || lengthen || shorten) begin
        resync_cnt_q <= resync_cnt_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, unmapped addresses give pslverr

  logic access;
  logic done;
  logic mapped;
  logic [31:0] rd_val;

  assign access = psel && penable;
  assign done = access && pready;
  assign mapped = (paddr == ADDR_CONFIG) || (paddr == ADDR_STATUS)
    || (paddr == ADDR_COUNTS);

  always_comb begin
    case (paddr)
      ADDR_CONFIG: rd_val = {13'h0000, cfg_q};
      ADDR_STATUS: rd_val = {24'h000000, sync_done_q, sampled_q, rx_s_q, 1'b0, seg_q};
      ADDR_COUNTS: rd_val = {16'h0000, resync_cnt_q, hard_cnt_q};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= access && !pready;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (ce && done && pwrite && (paddr == ADDR_CONFIG)) begin
      cfg_q <= pwdata[CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] gap_q;
  logic gap_ok_q;

  // Quantum length is only known once a tick follows a prescaler change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'h00;
      gap_ok_q <= 1'b1;
    end else if (ce) begin
      gap_q <= (tq_tick || restart) ? 8'h00 : gap_q + 8'h01;
      if (tq_tick || restart) begin
        gap_ok_q <= 1'b1;
      end else if (done && pwrite) begin
        gap_ok_q <= 1'b0;
      end
    end
  end

  chk_sync_len: assert property (@(posedge pclk) disable iff (!presetn)
    (seg_q == SEG_SYNC && tq_tick && !restart) |=> (seg_q == SEG_PROP))
    else $error("sync segment did not last one quantum");

  chk_seg_order: assert property (@(posedge pclk) disable iff (!presetn)
    (seg_q == SEG_PH1 && ce && !restart) |=> (seg_q == SEG_PH1 || seg_q == SEG_PH2))
    else $error("phase one not followed by phase two");

  chk_tq_length: assert property (@(posedge pclk) disable iff (!presetn)
    (tq_tick && gap_ok_q) |-> ({1'b0, gap_q} + 9'h001 == {2'h0, presc, 1'b1} + 9'h001))
    else $error("quantum length wrong");

  chk_sample_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_pt && ce) |=> (sample_strobe && sample_bit == $past(bit_val)
      && seg_q == SEG_PH2))
    else $error("sample strobe not at end of phase one");

  chk_ph2_floor: assert property (@(posedge pclk) disable iff (!presetn)
    ph2_base >= PROC_TIME_TQ && (ph2_mode || ph2_base >= ph1_len))
    else $error("phase two below processing time");

  chk_hard_restart: assert property (@(posedge pclk) disable iff (!presetn)
    hard_sync |=> (seg_q == SEG_SYNC && seg_cnt_q == 5'h00 && sync_done_q && bit_start))
    else $error("hard sync did not restart bit");

  chk_one_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_taken && ce) |=> (sync_done_q && !sync_taken))
    else $error("second sync in one bit");

  chk_tx_positive: assert property (@(posedge pclk) disable iff (!presetn)
    (transmitting && is_pos) |-> !(restart || lengthen))
    else $error("positive resync while transmitting");

  chk_ext_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (lengthen && ce) |=> (ext_q == $past(jw_len)))
    else $error("phase one lengthened by wrong amount");

  chk_cut_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (shorten && ce) |=> (cut_q == $past(jw_len) && ph2_eff >= 5'h01))
    else $error("phase two shortened by wrong amount");

  chk_edge_use: assert property (@(posedge pclk) disable iff (!presetn)
    sync_taken |-> (rx_prev_q && !rx_s_q && sampled_q))
    else $error("sync on an unqualified edge");

  chk_tx_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ((restart || natural_start) && ce) |=> (can_tx == $past(tx_bit) && bit_start))
    else $error("transmit bit not driven at bit start");

endmodule
`default_nettype wire

//--- core/quantum_prescaler.sv
// Time quantum generator: divides the clock into quanta of 2*(setting+1) cycles.
// Assumes ce gates every step and restart re-aligns the quantum.
`timescale 1ns/1ns
`default_nettype none
module quantum_prescaler #(
  parameter int W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic restart,
  input wire logic [W-1:0] setting,
  output logic half_tick,
  output logic tq_tick
);
  logic [W:0] cnt_q;
  logic [W:0] half_last;
  logic [W:0] full_last;

  // Quantum is TQ_BASE_PERIODS * (setting + 1) cycles
  assign half_last = {1'b0, setting};
  assign full_last = {setting, 1'b1};
  assign half_tick = ce && !restart && (cnt_q == half_last);
  assign tq_tick = ce && !restart && (cnt_q == full_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (restart || cnt_q >= full_last) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- pkg/can_bit_timing_pkg.sv
// Constants, field layout and state encoding for the CAN bit timing block.
// Assumes a 32-bit APB register bus and a single clock.
package can_bit_timing_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNTS = 12'h008;

  // Config register field positions
  localparam int CFG_PRESC_LSB = 0;
  localparam int CFG_PRESC_W = 6;
  localparam int CFG_JW_LSB = 6;
  localparam int CFG_PROP_LSB = 8;
  localparam int CFG_PH1_LSB = 11;
  localparam int CFG_PH2_LSB = 14;
  localparam int CFG_TRIPLE_BIT = 17;
  localparam int CFG_MODE_BIT = 18;
  localparam int CFG_W = 19;
  localparam logic [CFG_W-1:0] CFG_RESET = 19'h00000;

  // Segment and timing figures in time quanta; TQ_BASE_PERIODS is in clock cycles per prescaler step
  localparam logic [4:0] SYNC_SEG_TQ = 5'h01;
  localparam logic [4:0] PROC_TIME_TQ = 5'h02;
  localparam logic [4:0] PH2_MIN_TQ = 5'h02;
  localparam int TQ_BASE_PERIODS = 2;

  // Reset value of the last sampled bus level (recessive)
  localparam logic SAMPLED_RESET = 1'b1;

  typedef enum logic [3:0] {
    SEG_SYNC = 4'b0001,
    SEG_PROP = 4'b0010,
    SEG_PH1 = 4'b0100,
    SEG_PH2 = 4'b1000
  } seg_t;

endpackage

//--- sim/can_node_model.sv
// Another node on the shared CAN bus; on command it sends one dominant pulse.
// Assumes the wire is a wired-AND of this node and the block's transmit pin.
`timescale 1ns/1ns
`default_nettype none
module can_node_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [15:0] delay,
  input wire logic [15:0] len,
  input wire logic can_tx,
  output logic can_rx
);
  logic [1:0] st_q;
  logic [15:0] cnt_q;
  logic level_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wait, then hold dominant, then release to recessive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 2'h0;
      cnt_q <= 16'h0000;
      level_q <= 1'b1;
    end else begin
      case (st_q)
        2'h0: if (go) begin
          st_q <= 2'h1;
          cnt_q <= delay;
        end
        2'h1: if (cnt_q == 16'h0000) begin
          level_q <= 1'b0;
          cnt_q <= len;
          st_q <= 2'h2;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
        default: if (cnt_q == 16'h0000) begin
          level_q <= 1'b1;
          st_q <= 2'h0;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      endcase
    end
  end

  // Dominant wins on the wire
  assign can_rx = level_q & can_tx;
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench: APB register checks, sync, resync, sampling, transmit.
// Assumes one other node on the bus, modelled by can_node_model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import can_bit_timing_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cfg, rng;
  logic can_rx, can_tx, bus_idle, transmitting, tx_bit;
  logic bit_start, sample_strobe, sample_bit, node_go;
  logic [15:0] node_delay, node_len;
  int n_mismatch, tests_run, n, k, i;
  int rs_d[8] = '{53, 53, 53, 53, 53, 85, 85, 13};
  int rs_j[8] = '{0, 1, 2, 3, 0, 0, 3, 3};

  can_bit_timing_sync i_can_bit_timing_sync (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx),
    .bus_idle(bus_idle), .transmitting(transmitting), .tx_bit(tx_bit),
    .bit_start(bit_start), .sample_strobe(sample_strobe), .sample_bit(sample_bit));
  can_node_model i_can_node_model (.pclk(pclk), .presetn(presetn), .go(node_go),
    .delay(node_delay), .len(node_len), .can_tx(can_tx), .can_rx(can_rx));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected timing from a config word, in clock cycles
  function automatic int tq_of(input logic [31:0] c);
    return TQ_BASE_PERIODS * (int'(c[CFG_PRESC_LSB +: CFG_PRESC_W]) + 1);
  endfunction
  function automatic int samp_of(input logic [31:0] c);
    return (int'(SYNC_SEG_TQ) + int'(c[CFG_PROP_LSB +: 3]) + int'(c[CFG_PH1_LSB +: 3]) + 2)
      * tq_of(c);
  endfunction
  function automatic int nbt_of(input logic [31:0] c);
    int a;
    a = c[CFG_MODE_BIT] ? int'(c[CFG_PH2_LSB +: 3]) + 1 : int'(c[CFG_PH1_LSB +: 3]) + 1;
    a = (a < int'(PH2_MIN_TQ)) ? int'(PH2_MIN_TQ) : a;
    return samp_of(c) + a * tq_of(c);
  endfunction
  function automatic int gap_of(input logic [31:0] c, input int d, input logic t);
    int j;
    j = (int'(c[CFG_JW_LSB +: 2]) + 1) * tq_of(c);
    if (d + 3 < samp_of(c)) return nbt_of(c) + (t ? 0 : j);
    return nbt_of(c) - j;
  endfunction
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (j == 50) begin
      n_mismatch++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_pulse(input logic which);
    for (n = 1; n <= 3000; n++) begin
      @(posedge pclk);
      #1;
      if ((which ? sample_strobe : bit_start) === 1'b1) break;
    end
    if (n > 3000) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic pulse(input int d, input int ln);
    @(posedge pclk);
    node_delay <= d[15:0];
    node_len <= ln[15:0];
    node_go <= 1'b1;
    @(posedge pclk);
    node_go <= 1'b0;
  endtask
  task automatic set_cfg(input logic [31:0] c);
    apb(1'b1, ADDR_CONFIG, c);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config", rd, c & 32'h0007FFFF);
    wait_pulse(1'b0);
    wait_pulse(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, bus_idle, transmitting, node_go} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_bit = 1'b1;
    node_delay = 16'h0000;
    node_len = 16'h0000;
    rng = 32'd90;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("tx reset", can_tx, 1'b1);
    check("sample reset", sample_bit, SAMPLED_RESET);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config reset", rd, CFG_RESET);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    check("unmapped wr err", err, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped rd", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    check("status wr err", err, 1'b0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config kept", rd, CFG_RESET);
    // Hard sync on idle bus, fixed corner configs then random ones
    for (k = 0; k < 6; k++) begin
      cfg = (k == 0) ? 32'h00043FC1 : (k == 1) ? 32'h0001C000 : rnd() & 32'hFFFDFFC3;
      set_cfg(cfg);
      @(posedge pclk);
      bus_idle <= 1'b1;
      pulse(0, samp_of(cfg) + 8);
      wait_pulse(1'b0);
      check("hard sync delay", (n <= 8) ? 32'h1 : 32'h0, 32'h1);
      wait_pulse(1'b1);
      check("sample point", 32'(n), 32'(samp_of(cfg)));
      check("sample dominant", sample_bit, 1'b0);
      wait_pulse(1'b0);
      check("phase two", 32'(n), 32'(nbt_of(cfg) - samp_of(cfg)));
      @(posedge pclk);
      bus_idle <= 1'b0;
      wait_pulse(1'b0);
    end
    // Resync: positive large, blocked while sending, negative large, small
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      transmitting <= (i == 4);
      cfg = 32'h00003803 | (rs_j[i] << CFG_JW_LSB);
      set_cfg(cfg);
      pulse(rs_d[i], 8);
      wait_pulse(1'b0);
      if (i < 7) check("resync gap", 32'(n + 2), 32'(gap_of(cfg, rs_d[i], i == 4)));
      else check("restart gap", (n >= 16 && n <= 24) ? 32'h1 : 32'h0, 32'h1);
    end
    // Majority sampling against a short dominant window
    @(posedge pclk);
    transmitting <= 1'b1;
    for (i = 0; i < 4; i++) begin
      cfg = 32'h00003807 | (i[1] << CFG_TRIPLE_BIT);
      set_cfg(cfg);
      pulse(samp_of(cfg) - (i[0] ? 16 : 12), 20);
      wait_pulse(1'b1);
      check("triple sample", sample_bit, (i == 2) ? 1'b1 : 1'b0);
    end
    apb(1'b0, ADDR_COUNTS, 32'h0);
    check("sync counts", rd, 32'h00000706);
    @(posedge pclk);
    tx_bit <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    check("tx held", can_tx, 1'b1);
    wait_pulse(1'b0);
    check("tx dominant", can_tx, 1'b0);
    @(posedge pclk);
    tx_bit <= 1'b1;
    wait_pulse(1'b0);
    check("tx recessive", can_tx, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
